// File: core/led_pwm_brightness_control.sv
// What this block does
// RULE1: PWM from internal 20 MHz step, eight frequencies
// RULE2: Resolution drops one bit per frequency doubling
// RULE3: Detect string count, set matching phase shift
// RULE4: Joined channel groups get 120, 180, none
// RULE5: Unknown wiring falls back to six channels
// RULE6: Detected layout readable in 3-bit status
// RULE7: Wiring changes only while powered off
// RULE8: Per-channel selector picks display or cluster
// RULE9: Six 16-bit cluster levels set by software
// RULE10: Six-bit mask removes channels from boost loop
// RULE11: Reset clears mask and all selectors
// RULE12: Source mode picks pin duty or register
// RULE13: Display path only: sloper on, hybrid off
// RULE14: Hybrid threshold at 12.5% or 0%
// RULE15: 3-bit slope time, zero disables, 200 ms
// RULE16: Smoothing bit adds extra easing, default on
// RULE17: Sink settings apply together on load latch
// RULE18: Steps equal oscillator rate over PWM rate
// RULE19: Sloper moves in even steps to target
module led_pwm_brightness_control #(
	parameter int SLOPE_BASE = led_pwm_pkg::SLOPE_BASE_CYCLES,
	parameter int PIN_BITS = led_pwm_pkg::PIN_WIN_BITS
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	// Register port
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	// Board straps and brightness input
	input wire logic PWM_IN_I,
	input wire logic [2:0] PWM_FREQ_SEL_I,
	input wire logic [5:0] STRING_PRESENT_I,
	input wire logic [1:0] STRING_JOIN_I,
	// Channel drive
	output logic [5:0] LED_PWM_O,
	output logic [15:0] DISP_CURRENT_O,
	output logic [71:0] CHANNEL_SINK_O,
	output logic [5:0] BOOST_EXCLUDE_O
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [2:0] decode_layout(input logic [5:0] present,
			input logic [1:0] join_sel);
		logic [2:0] lay;
		lay = led_pwm_pkg::LAY_6CH; // RULE5
		if (present == 6'h3F && join_sel == 2'h1) begin
			lay = led_pwm_pkg::LAY_3X300; // RULE4
		end else if (present == 6'h3F && join_sel == 2'h2) begin
			lay = led_pwm_pkg::LAY_2X450;
		end else if (present == 6'h3F && join_sel == 2'h3) begin
			lay = led_pwm_pkg::LAY_1X900;
		end else if (join_sel == 2'h0) begin
			case (present) // RULE3
				6'h1F: lay = led_pwm_pkg::LAY_5CH;
				6'h0F: lay = led_pwm_pkg::LAY_4CH;
				6'h07: lay = led_pwm_pkg::LAY_3CH;
				6'h03: lay = led_pwm_pkg::LAY_2CH;
				default: lay = led_pwm_pkg::LAY_6CH;
			endcase
		end
		return lay;
	endfunction

	// Phase as a fraction of the period, in 1/2^17 units
	function automatic logic [16:0] phase_frac(input logic [2:0] lay,
			input int ch);
		logic [2:0] slot;
		logic [2:0] n;
		logic [16:0] recip;
		logic [19:0] prod;
		slot = 3'(ch);
		n = 3'h6;
		recip = led_pwm_pkg::RECIP_6;
		case (lay)
			led_pwm_pkg::LAY_5CH: begin
				n = 3'h5;
				recip = led_pwm_pkg::RECIP_5;
			end
			led_pwm_pkg::LAY_4CH: begin
				n = 3'h4;
				recip = led_pwm_pkg::RECIP_4;
			end
			led_pwm_pkg::LAY_3CH: begin
				n = 3'h3;
				recip = led_pwm_pkg::RECIP_3;
			end
			led_pwm_pkg::LAY_2CH: begin
				n = 3'h2;
				recip = led_pwm_pkg::RECIP_2;
			end
			led_pwm_pkg::LAY_3X300: begin
				slot = 3'(ch / 2);
				n = 3'h3;
				recip = led_pwm_pkg::RECIP_3;
			end
			led_pwm_pkg::LAY_2X450: begin
				slot = 3'(ch / 3);
				n = 3'h2;
				recip = led_pwm_pkg::RECIP_2;
			end
			led_pwm_pkg::LAY_1X900: begin
				slot = 3'h0;
			end
			default: begin
				n = 3'h6;
			end
		endcase
		if (slot >= n) begin
			slot = 3'h0;
		end
		prod = 20'(slot) * 20'(recip);
		return prod[16:0];
	endfunction

	// Level (16 bit) to on-time over a 2^(17-code) step period
	function automatic logic [16:0] duty_count(input logic [15:0] level,
			input logic [2:0] code);
		return {level, 1'b0} >> code; // RULE2
	endfunction

	function automatic logic [10:0] slope_ms(input logic [2:0] sel);
		case (sel) // RULE15
			3'h1: return 11'd50;
			3'h2: return 11'd100;
			3'h3: return 11'd200;
			3'h4: return 11'd300;
			3'h5: return 11'd500;
			3'h6: return 11'd1000;
			default: return 11'd2000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register port

	led_pwm_pkg::bus_req_t req;
	assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	logic [15:0] disp_level_q;
	logic [15:0] setup_q;
	logic [5:0] rail_mask_q;
	logic [2:0] source_sel_q [6];
	logic [15:0] cluster_q [6];
	logic [11:0] sink_pend_q [6];
	logic [11:0] sink_act_q [6];
	logic [2:0] layout_q;
	logic [2:0] freq_code_q;
	led_pwm_pkg::boot_state_t state_q;

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			disp_level_q <= led_pwm_pkg::DISP_RST;
			setup_q <= led_pwm_pkg::SETUP_RST; // RULE13 RULE15 RULE16
			rail_mask_q <= led_pwm_pkg::RAIL_RST; // RULE11
		end else if (req.wr && req.addr == led_pwm_pkg::OFS_DISP_LEVEL) begin
			disp_level_q <= req.wdata;
		end else if (req.wr && req.addr == led_pwm_pkg::OFS_USER_SETUP) begin
			setup_q <= {9'h000, req.wdata[6:0]};
		end else if (req.wr && req.addr == led_pwm_pkg::OFS_RAIL_MASK) begin
			rail_mask_q <= req.wdata[5:0]; // RULE10
		end
	end

	for (genvar c = 0; c < 6; c++) begin : g_regs
		always_ff @(posedge CLOCK_I) begin
			if (!RESET_N_I) begin
				source_sel_q[c] <= led_pwm_pkg::SOURCE_RST; // RULE11
				cluster_q[c] <= led_pwm_pkg::CLUSTER_RST;
				sink_pend_q[c] <= led_pwm_pkg::SINK_RST;
				sink_act_q[c] <= led_pwm_pkg::SINK_RST;
			end else begin
				if (req.wr && req.addr == led_pwm_pkg::OFS_SOURCE_BASE + 8'(c)) begin
					source_sel_q[c] <= req.wdata[2:0]; // RULE8
				end
				if (req.wr && req.addr == led_pwm_pkg::OFS_CLUSTER_BASE + 8'(c)) begin
					cluster_q[c] <= req.wdata; // RULE9
				end
				if (req.wr && req.addr == led_pwm_pkg::OFS_SINK_BASE + 8'(c)) begin
					sink_pend_q[c] <= req.wdata[11:0];
				end
				if (req.wr && req.addr == led_pwm_pkg::OFS_LOAD_LATCH &&
						req.wdata[led_pwm_pkg::LOAD_BIT]) begin
					sink_act_q[c] <= sink_pend_q[c]; // RULE17
				end
			end
		end
		assign CHANNEL_SINK_O[c*12 +: 12] = sink_act_q[c];
	end

	assign BOOST_EXCLUDE_O = rail_mask_q; // RULE10

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			RDATA_O <= 16'h0000;
		end else if (!req.rd) begin
			RDATA_O <= 16'h0000;
		end else if (req.addr == led_pwm_pkg::OFS_DISP_LEVEL) begin
			RDATA_O <= disp_level_q;
		end else if (req.addr == led_pwm_pkg::OFS_USER_SETUP) begin
			RDATA_O <= setup_q;
		end else if (req.addr == led_pwm_pkg::OFS_RAIL_MASK) begin
			RDATA_O <= {10'h000, rail_mask_q};
		end else if (req.addr == led_pwm_pkg::OFS_STATUS) begin
			RDATA_O <= {12'h000, state_q == led_pwm_pkg::ST_RUN,
				layout_q}; // RULE6
		end else if (req.addr >= led_pwm_pkg::OFS_SOURCE_BASE &&
				req.addr < led_pwm_pkg::OFS_SOURCE_BASE + 8'h06) begin
			RDATA_O <= {13'h0000, source_sel_q[req.addr[2:0]]};
		end else if (req.addr >= led_pwm_pkg::OFS_CLUSTER_BASE &&
				req.addr < led_pwm_pkg::OFS_CLUSTER_BASE + 8'h06) begin
			RDATA_O <= cluster_q[req.addr[2:0]];
		end else if (req.addr >= led_pwm_pkg::OFS_SINK_BASE &&
				req.addr < led_pwm_pkg::OFS_SINK_BASE + 8'h06) begin
			RDATA_O <= {4'h0, sink_pend_q[req.addr[2:0]]};
		end else begin
			RDATA_O <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-up wiring detection

	// Straps are caught once after reset; rewiring while running is not
	// followed, since the board may only change it while powered off
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			state_q <= led_pwm_pkg::ST_CAPTURE;
			layout_q <= led_pwm_pkg::LAY_6CH;
			freq_code_q <= 3'h0;
		end else begin
			case (state_q)
				led_pwm_pkg::ST_CAPTURE: begin
					layout_q <= decode_layout(STRING_PRESENT_I,
						STRING_JOIN_I); // RULE3 RULE7
					freq_code_q <= PWM_FREQ_SEL_I; // RULE1
					state_q <= led_pwm_pkg::ST_RUN;
				end
				led_pwm_pkg::ST_RUN: begin
					state_q <= led_pwm_pkg::ST_RUN;
				end
				default: begin
					state_q <= led_pwm_pkg::ST_CAPTURE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Oscillator step and shared period counter

	logic [5:0] osc_acc_q;
	logic osc_tick;
	logic [16:0] base_q;
	logic [16:0] period_mask;

	assign osc_tick = (osc_acc_q + 6'(led_pwm_pkg::OSC_ACC_STEP)) >=
		6'(led_pwm_pkg::OSC_ACC_WRAP);
	assign period_mask = led_pwm_pkg::CNT_FULL >> freq_code_q; // RULE18

	// Two of every five system clocks give the 20 MHz step rate
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			osc_acc_q <= 6'h00;
		end else if (osc_tick) begin
			osc_acc_q <= osc_acc_q + 6'(led_pwm_pkg::OSC_ACC_STEP) -
				6'(led_pwm_pkg::OSC_ACC_WRAP); // RULE1
		end else begin
			osc_acc_q <= osc_acc_q + 6'(led_pwm_pkg::OSC_ACC_STEP);
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			base_q <= 17'h0_0000;
		end else if (osc_tick && state_q == led_pwm_pkg::ST_RUN) begin
			base_q <= (base_q + 17'h0_0001) & period_mask; // RULE18
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Display path: source, sloper, smoothing, hybrid split

	logic [15:0] win_q;
	logic [15:0] high_q;
	logic [15:0] pin_level_q;
	logic win_end;

	assign win_end = win_q == 16'(({17'h0_0000, 1'b1} << PIN_BITS) - 1);

	// Pin duty is measured over a fixed window, independent of LED rate
	// The last sample of a window is dropped so a full count fits 16 bits
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			win_q <= 16'h0000;
			high_q <= 16'h0000;
			pin_level_q <= 16'h0000;
		end else if (win_end) begin
			win_q <= 16'h0000;
			high_q <= 16'h0000;
			pin_level_q <= high_q << (16 - PIN_BITS);
		end else begin
			win_q <= win_q + 16'h0001;
			high_q <= high_q + 16'(PWM_IN_I);
		end
	end

	logic [15:0] target;
	logic [15:0] target_q;
	logic [23:0] ramp_q;
	logic signed [16:0] step_q;
	logic [8:0] steps_left_q;
	logic [11:0] base_cnt_q;
	logic [10:0] ms_cnt_q;
	logic base_tick;
	logic slope_tick;
	logic [2:0] slope_sel;

	assign target = setup_q[led_pwm_pkg::SETUP_SRC_BIT] ?
		disp_level_q : pin_level_q; // RULE12
	assign slope_sel = setup_q[led_pwm_pkg::SETUP_SLOPE_LSB +: 3];
	assign base_tick = base_cnt_q == 12'(SLOPE_BASE - 1);
	assign slope_tick = base_tick && ms_cnt_q >= slope_ms(slope_sel) - 11'd1;

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			base_cnt_q <= 12'h000;
			ms_cnt_q <= 11'h000;
		end else if (base_tick) begin
			base_cnt_q <= 12'h000;
			ms_cnt_q <= slope_tick ? 11'h000 : ms_cnt_q + 11'h001;
		end else begin
			base_cnt_q <= base_cnt_q + 12'h001;
		end
	end

	// 256 equal steps of (new - old)/256 land exactly on the target
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			target_q <= 16'h0000;
			ramp_q <= 24'h00_0000;
			step_q <= 17'sh0_0000;
			steps_left_q <= 9'h000;
		end else if (slope_sel == led_pwm_pkg::SLOPE_OFF) begin
			target_q <= target; // RULE15
			ramp_q <= {target, 8'h00};
			steps_left_q <= 9'h000;
		end else if (target != target_q) begin
			target_q <= target;
			step_q <= $signed({1'b0, target}) -
				$signed({1'b0, ramp_q[23:8]}); // RULE19
			steps_left_q <= 9'h100;
		end else if (slope_tick && steps_left_q != 9'h000) begin
			ramp_q <= 24'($signed({1'b0, ramp_q}) + 25'(step_q)); // RULE19
			steps_left_q <= steps_left_q - 9'h001;
		end
	end

	logic [15:0] smooth_q;
	logic signed [16:0] smooth_diff;

	assign smooth_diff = $signed({1'b0, ramp_q[23:8]}) -
		$signed({1'b0, smooth_q});

	// Easing trails the linear ramp; small residues snap to avoid a stall
	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			smooth_q <= 16'h0000;
		end else if (!setup_q[led_pwm_pkg::SETUP_SMOOTH_BIT]) begin
			smooth_q <= ramp_q[23:8];
		end else if (base_tick) begin
			if (smooth_diff > -17'sd8 && smooth_diff < 17'sd8) begin
				smooth_q <= ramp_q[23:8]; // RULE16
			end else begin
				smooth_q <= 16'(smooth_q + 16'(smooth_diff >>> 3)); // RULE16
			end
		end
	end

	logic [15:0] disp_pwm_q;
	logic [1:0] dim_mode;

	assign dim_mode = setup_q[led_pwm_pkg::SETUP_DIM_LSB +: 2];

	always_ff @(posedge CLOCK_I) begin
		if (!RESET_N_I) begin
			disp_pwm_q <= 16'h0000;
			DISP_CURRENT_O <= led_pwm_pkg::LEVEL_FULL;
		end else if (dim_mode == led_pwm_pkg::DIM_HYB_12P5 &&
				smooth_q < led_pwm_pkg::HYB_THRESH) begin
			disp_pwm_q <= smooth_q << 3; // RULE14
			DISP_CURRENT_O <= led_pwm_pkg::HYB_THRESH;
		end else if (dim_mode == led_pwm_pkg::DIM_HYB_12P5 ||
				dim_mode == led_pwm_pkg::DIM_HYB_0) begin
			disp_pwm_q <= led_pwm_pkg::LEVEL_FULL; // RULE14
			DISP_CURRENT_O <= smooth_q;
		end else begin
			disp_pwm_q <= smooth_q; // RULE13
			DISP_CURRENT_O <= led_pwm_pkg::LEVEL_FULL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channels

	for (genvar c = 0; c < 6; c++) begin : g_ch
		logic [15:0] level;
		logic [16:0] offset;

		// Selector 1..5 names a cluster level; others follow the display
		assign level = (source_sel_q[c] >= 3'h1 && source_sel_q[c] <= 3'h5) ?
			cluster_q[source_sel_q[c]] : disp_pwm_q; // RULE8 RULE9
		assign offset = phase_frac(layout_q, c) >> freq_code_q; // RULE3

		led_pwm_channel u_ch (
			.clk_i(CLOCK_I),
			.rst_n_i(RESET_N_I),
			.tick_i(osc_tick),
			.base_i(base_q),
			.offset_i(offset),
			.mask_i(period_mask),
			.duty_i(duty_count(level, freq_code_q)),
			.pwm_o(LED_PWM_O[c])
		);
	end

endmodule

// File: core/led_pwm_pkg.sv
package led_pwm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int CH_N = 6;
	localparam int CNT_W = 17;
	localparam int SINK_W = 12;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] OFS_DISP_LEVEL = 8'h00;
	localparam logic [7:0] OFS_USER_SETUP = 8'h01;
	localparam logic [7:0] OFS_RAIL_MASK = 8'h02;
	localparam logic [7:0] OFS_LOAD_LATCH = 8'h03;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SOURCE_BASE = 8'h10;
	localparam logic [7:0] OFS_CLUSTER_BASE = 8'h20;
	localparam logic [7:0] OFS_SINK_BASE = 8'h30;

	////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int SETUP_DIM_LSB = 0;
	localparam int SETUP_SRC_BIT = 2;
	localparam int SETUP_SLOPE_LSB = 3;
	localparam int SETUP_SMOOTH_BIT = 6;
	localparam int LOAD_BIT = 0;
	localparam int STATUS_DONE_BIT = 3;
	localparam logic [15:0] SETUP_RST = 16'h0058;
	localparam logic [15:0] DISP_RST = 16'h0000;
	localparam logic [5:0] RAIL_RST = 6'h00;
	localparam logic [2:0] SOURCE_RST = 3'h0;
	localparam logic [15:0] CLUSTER_RST = 16'h0000;
	localparam logic [11:0] SINK_RST = 12'hFFF;

	////////////////////////////////////////////////////////////////////////
	// Dimming modes and level thresholds
	localparam logic [1:0] DIM_PWM = 2'h0;
	localparam logic [1:0] DIM_HYB_12P5 = 2'h1;
	localparam logic [1:0] DIM_HYB_0 = 2'h2;
	localparam logic [15:0] HYB_THRESH = 16'h2000;
	localparam logic [15:0] LEVEL_FULL = 16'hFFFF;
	localparam logic [2:0] SLOPE_OFF = 3'h0;

	////////////////////////////////////////////////////////////////////////
	// String layouts
	localparam logic [2:0] LAY_6CH = 3'h0;
	localparam logic [2:0] LAY_5CH = 3'h1;
	localparam logic [2:0] LAY_4CH = 3'h2;
	localparam logic [2:0] LAY_3CH = 3'h3;
	localparam logic [2:0] LAY_2CH = 3'h4;
	localparam logic [2:0] LAY_3X300 = 3'h5;
	localparam logic [2:0] LAY_2X450 = 3'h6;
	localparam logic [2:0] LAY_1X900 = 3'h7;
	// Period fraction per slot, in units of 1/2^17 of a period
	localparam logic [16:0] RECIP_6 = 17'h0_5555;
	localparam logic [16:0] RECIP_5 = 17'h0_6666;
	localparam logic [16:0] RECIP_4 = 17'h0_8000;
	localparam logic [16:0] RECIP_3 = 17'h0_AAAA;
	localparam logic [16:0] RECIP_2 = 17'h1_0000;
	localparam logic [16:0] CNT_FULL = 17'h1_FFFF;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int OSC_HZ = 20_000_000;
	localparam int OSC_ACC_STEP = OSC_HZ / 1_000_000;
	localparam int OSC_ACC_WRAP = CLK_HZ / 1_000_000;
	localparam int SLOPE_STEPS_LOG = 8;
	localparam int SLOPE_UNIT_US = 1000;
	localparam int SLOPE_BASE_CYCLES =
		(SLOPE_UNIT_US * (CLK_HZ / 1_000_000)) >> SLOPE_STEPS_LOG;
	localparam int PIN_WIN_BITS = 16;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef enum logic [1:0] {
		ST_CAPTURE = 2'b01,
		ST_RUN = 2'b10
	} boot_state_t;

endpackage

// File: core/led_pwm_channel.sv
module led_pwm_channel (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Time base
	input wire logic tick_i,
	input wire logic [16:0] base_i,
	input wire logic [16:0] offset_i,
	input wire logic [16:0] mask_i,
	// Requested on-time in oscillator steps
	input wire logic [16:0] duty_i,
	// Channel waveform
	output logic pwm_o
);

	logic [16:0] pos;
	logic [16:0] duty_q;

	assign pos = (base_i + offset_i) & mask_i;

	// Duty taken only at the channel's own period start, so a new level
	// never cuts a pulse short mid-period
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			duty_q <= 17'h0_0000;
		end else if (tick_i && pos == 17'h0_0000) begin
			duty_q <= duty_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pwm_o <= 1'b0;
		end else begin
			pwm_o <= (pos < duty_q);
		end
	end

endmodule

// File: tb/led_pwm_chk.sv
module led_pwm_chk #(
	parameter int SLOPE_BASE = 2,
	parameter int PIN_BITS = 4
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	// Register port
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [15:0] RDATA_O,
	// Channel drive
	input wire logic [5:0] LED_PWM_O,
	input wire logic [15:0] DISP_CURRENT_O,
	input wire logic [71:0] CHANNEL_SINK_O,
	input wire logic [5:0] BOOST_EXCLUDE_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);

	logic mw_w;
	logic ld_w;
	assign mw_w = WR_I && ADDR_I == led_pwm_pkg::OFS_RAIL_MASK;
	assign ld_w = WR_I && ADDR_I == led_pwm_pkg::OFS_LOAD_LATCH && WDATA_I[0];

	////////////////////////////////////////////////////////////////////////
	sequence s_rd(logic [7:0] a);
		RD_I && ADDR_I == a;
	endsequence
	sequence s_mask_wr;
		mw_w ##1 !mw_w;
	endsequence

	property p_latch_rd;
		s_rd(led_pwm_pkg::OFS_LOAD_LATCH) |=> RDATA_O == 16'h0000;
	endproperty
	a_latch_rd: assert property (p_latch_rd)
		else $error("load latch read not zero");
	property p_status_rd;
		s_rd(led_pwm_pkg::OFS_STATUS) |=> RDATA_O[15:4] == 12'h000;
	endproperty
	a_status_rd: assert property (p_status_rd)
		else $error("status upper bits set");
	property p_setup_rd;
		s_rd(led_pwm_pkg::OFS_USER_SETUP) |=> RDATA_O[15:7] == 9'h000;
	endproperty
	a_setup_rd: assert property (p_setup_rd)
		else $error("setup upper bits set");
	property p_mask_rd;
		s_rd(led_pwm_pkg::OFS_RAIL_MASK) |=> RDATA_O[15:6] == 10'h000;
	endproperty
	a_mask_rd: assert property (p_mask_rd)
		else $error("rail mask upper bits set");
	property p_sel_rd;
		RD_I && ADDR_I[7:4] == 4'h1 && ADDR_I[3:0] < 4'h6
			|=> RDATA_O[15:3] == 13'h0000;
	endproperty
	a_sel_rd: assert property (p_sel_rd)
		else $error("selector upper bits set");
	property p_mask_wr;
		s_mask_wr |=> BOOST_EXCLUDE_O == $past(WDATA_I[5:0], 2);
	endproperty
	a_mask_wr: assert property (p_mask_wr)
		else $error("rail mask output not written value");
	property p_mask_hold;
		$changed(BOOST_EXCLUDE_O) |-> $past(mw_w) || $past(mw_w, 2);
	endproperty
	a_mask_hold: assert property (p_mask_hold)
		else $error("rail mask output moved without write");
	property p_sink_hold;
		$changed(CHANNEL_SINK_O) |-> $past(ld_w) || $past(ld_w, 2);
	endproperty
	a_sink_hold: assert property (p_sink_hold)
		else $error("sink settings moved without load");
	// Checked through reset itself, so no disable here
	property p_rst;
		disable iff (1'b0)
		!RESET_N_I |=> RDATA_O == 16'h0000 && LED_PWM_O == 6'h00
			&& DISP_CURRENT_O == 16'hFFFF && BOOST_EXCLUDE_O == 6'h00
			&& CHANNEL_SINK_O == {6{12'hFFF}};
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not at reset values");
endmodule

bind led_pwm_brightness_control led_pwm_chk #(
	.SLOPE_BASE(SLOPE_BASE),
	.PIN_BITS(PIN_BITS)
) led_pwm_chk_inst (
	.CLOCK_I(CLOCK_I),
	.RESET_N_I(RESET_N_I),
	.ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I),
	.WR_I(WR_I),
	.RD_I(RD_I),
	.RDATA_O(RDATA_O),
	.LED_PWM_O(LED_PWM_O),
	.DISP_CURRENT_O(DISP_CURRENT_O),
	.CHANNEL_SINK_O(CHANNEL_SINK_O),
	.BOOST_EXCLUDE_O(BOOST_EXCLUDE_O)
);

// File: tb/led_string_model.sv
module led_string_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Wiring asked for by the bench
	input wire logic [5:0] want_present_i,
	input wire logic [1:0] want_join_i,
	// Strings and on-time counters
	input wire logic [5:0] pwm_i,
	input wire logic clr_i,
	output logic [5:0] present_o,
	output logic [1:0] join_o,
	output logic [15:0] on_cnt_o [6]
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		present_o = 6'h3F;
		join_o = 2'h0;
	end
	// Rewiring a live device is not allowed, so only while held off
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			present_o <= want_present_i;
			join_o <= want_join_i;
		end
	end
	always @(posedge clk_i) begin
		for (int c = 0; c < 6; c++) begin
			if (clr_i)
				on_cnt_o[c] <= 16'h0000;
			else if (pwm_i[c] === 1'b1)
				on_cnt_o[c] <= on_cnt_o[c] + 16'h0001;
		end
	end
endmodule

// File: tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CEIL = 90000;
	logic clock;
	logic reset_n;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	logic pwm_in;
	logic [2:0] freq_sel;
	logic [5:0] want_present;
	logic [1:0] want_join;
	logic [5:0] present;
	logic [1:0] join_sel;
	logic [5:0] led_pwm;
	logic [15:0] disp_cur;
	logic [71:0] sink;
	logic [5:0] boost_ex;
	logic clr;
	logic [15:0] on_cnt [6];
	logic [15:0] r;
	int miscompares;
	int n_checks;
	int cyc;

	led_pwm_brightness_control #(.SLOPE_BASE(2), .PIN_BITS(4))
	led_pwm_brightness_control_inst (
		.CLOCK_I(clock), .RESET_N_I(reset_n), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.PWM_IN_I(pwm_in), .PWM_FREQ_SEL_I(freq_sel),
		.STRING_PRESENT_I(present), .STRING_JOIN_I(join_sel),
		.LED_PWM_O(led_pwm), .DISP_CURRENT_O(disp_cur),
		.CHANNEL_SINK_O(sink), .BOOST_EXCLUDE_O(boost_ex)
	);
	led_string_model led_string_model_inst (
		.clk_i(clock), .rst_n_i(reset_n), .want_present_i(want_present),
		.want_join_i(want_join), .pwm_i(led_pwm), .clr_i(clr),
		.present_o(present), .join_o(join_sel), .on_cnt_o(on_cnt)
	);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == CEIL) begin
			miscompares++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic do_reset(input logic [5:0] p, input logic [1:0] j,
		input logic [2:0] f);
		@(posedge clock);
		want_present <= p;
		want_join <= j;
		freq_sel <= f;
		reset_n <= 1'b0;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		wait_n(2);
	endtask
	// Bounded wait for a low-to-high edge on one channel
	task automatic wait_rise(input int c, output int t);
		int n;
		n = 0;
		while (led_pwm[c] !== 1'b0 && n < 6000) begin
			@(posedge clock);
			n++;
		end
		while (led_pwm[c] !== 1'b1 && n < 12000) begin
			@(posedge clock);
			n++;
		end
		t = int'($time / 20);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_reg(led_pwm_pkg::OFS_USER_SETUP, r);
		chk(r, 16'h0058);
		rd_reg(led_pwm_pkg::OFS_RAIL_MASK, r);
		chk(r, 16'h0000);
		for (int c = 0; c < 6; c++) begin
			rd_reg(led_pwm_pkg::OFS_SOURCE_BASE + 8'(c), r);
			chk(r, 16'h0000);
		end
		rd_reg(led_pwm_pkg::OFS_SINK_BASE, r);
		chk(r, 16'h0FFF);
		chk(boost_ex, 6'h00);
		$display("test reset done");
	endtask
	task automatic t_layout();
		logic [15:0] tb [9] = '{16'h3F00, 16'h1F01, 16'h0F02, 16'h0703,
			16'h0304, 16'h3F15, 16'h3F26, 16'h3F37, 16'h2D00};
		for (int i = 0; i < 9; i++) begin
			do_reset(tb[i][13:8], tb[i][5:4], 3'h7);
			rd_reg(led_pwm_pkg::OFS_STATUS, r);
			chk(r[3:0], {1'b1, tb[i][2:0]});
		end
		$display("test layout done");
	endtask
	task automatic t_regs();
		wr_reg(led_pwm_pkg::OFS_RAIL_MASK, 16'h0018);
		wait_n(3);
		chk(boost_ex, 6'h18);
		wr_reg(led_pwm_pkg::OFS_SINK_BASE + 8'h02, 16'h0123);
		wait_n(3);
		chk(sink, {6{12'hFFF}});
		rd_reg(led_pwm_pkg::OFS_SINK_BASE + 8'h02, r);
		chk(r, 16'h0123);
		wr_reg(led_pwm_pkg::OFS_LOAD_LATCH, 16'h0001);
		rd_reg(led_pwm_pkg::OFS_LOAD_LATCH, r);
		chk(r, 16'h0000);
		wait_n(2);
		chk(sink, {{3{12'hFFF}}, 12'h123, {2{12'hFFF}}});
		rd_reg(8'h7F, r);
		chk(r, 16'h0000);
		$display("test registers done");
	endtask
	// Setup word, level, expected current scale
	task automatic t_dim();
		logic [47:0] tb [4] = '{48'h0004_1000_FFFF, 48'h0005_1000_2000,
			48'h0005_9000_9000, 48'h0006_1000_1000};
		for (int i = 0; i < 4; i++) begin
			wr_reg(led_pwm_pkg::OFS_USER_SETUP, tb[i][47:32]);
			wr_reg(led_pwm_pkg::OFS_DISP_LEVEL, tb[i][31:16]);
			wait_n(40);
			chk(disp_cur, tb[i][15:0]);
		end
		@(posedge clock);
		pwm_in <= 1'b1;
		wr_reg(led_pwm_pkg::OFS_USER_SETUP, 16'h0002);
		wait_n(60);
		chk(72'(disp_cur >= 16'hF000), 72'h1);
		@(posedge clock);
		pwm_in <= 1'b0;
		wait_n(60);
		chk(disp_cur, 16'h0000);
		$display("test dimming done");
	endtask
	task automatic t_phase(input logic [2:0] f);
		int t0;
		int t1;
		int t2;
		int per;
		per = (5 << (17 - f)) / 2;
		do_reset(6'h3F, 2'h0, f);
		wr_reg(led_pwm_pkg::OFS_USER_SETUP, 16'h0004);
		wr_reg(led_pwm_pkg::OFS_DISP_LEVEL, 16'h8000);
		wait_n(2 * per + 50);
		wait_rise(0, t0);
		wait_rise(1, t1);
		wait_rise(0, t2);
		chk(72'(t2 - t0 >= per - 1 && t2 - t0 <= per + 1), 72'h1);
		chk(72'((per - t1 + t0) * 6 >= per - 18), 72'h1);
		chk(72'((per - t1 + t0) * 6 <= per + 18), 72'h1);
		$display("test phase done");
	endtask
	task automatic t_cluster();
		int per;
		per = 5120;
		wr_reg(led_pwm_pkg::OFS_SOURCE_BASE + 8'h04, 16'h0004);
		wr_reg(led_pwm_pkg::OFS_SOURCE_BASE + 8'h05, 16'h0005);
		wr_reg(led_pwm_pkg::OFS_CLUSTER_BASE + 8'h04, 16'h8000);
		wr_reg(led_pwm_pkg::OFS_CLUSTER_BASE + 8'h05, 16'h0000);
		wr_reg(led_pwm_pkg::OFS_DISP_LEVEL, 16'h0000);
		wait_n(per + 50);
		@(posedge clock);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		wait_n(2 * per);
		chk(72'(on_cnt[4] >= 16'd5114 && on_cnt[4] <= 16'd5126), 1);
		chk(on_cnt[5], 16'h0000);
		chk(on_cnt[0], 16'h0000);
		rd_reg(led_pwm_pkg::OFS_CLUSTER_BASE + 8'h04, r);
		chk(r, 16'h8000);
		$display("test cluster done");
	endtask
	// Ramp over 256 steps of 50 * SLOPE_BASE cycles each
	task automatic t_slope();
		wr_reg(led_pwm_pkg::OFS_USER_SETUP, 16'h000E);
		wr_reg(led_pwm_pkg::OFS_DISP_LEVEL, 16'h8000);
		wait_n(12800);
		chk(72'(disp_cur >= 16'h3E00 && disp_cur <= 16'h4200), 1);
		wait_n(13200);
		chk(disp_cur, 16'h8000);
		$display("test slope done");
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		reset_n = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		pwm_in = 1'b0;
		freq_sel = 3'h7;
		want_present = 6'h3F;
		want_join = 2'h0;
		clr = 1'b0;
		do_reset(6'h3F, 2'h0, 3'h7);
		t_reset();
		t_layout();
		t_regs();
		t_dim();
		t_phase(3'h7);
		t_phase(3'h6);
		t_cluster();
		t_slope();
		stop_test();
	end
endmodule
